// *** design/uart_flow_pkg.sv ***
// Register map, field layout, reset values and states of the flow control block
package uart_flow_pkg;

  // ---------------------------------------------------------------
  // Register indices on the host port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_IER   = 4'h0;
  localparam logic [3:0] ADDR_ISR   = 4'h1;  // Read status, write FIFO control
  localparam logic [3:0] ADDR_LCR   = 4'h2;
  localparam logic [3:0] ADDR_MCR   = 4'h3;
  localparam logic [3:0] ADDR_LSR   = 4'h4;
  localparam logic [3:0] ADDR_MSR   = 4'h5;
  localparam logic [3:0] ADDR_SPR   = 4'h6;
  localparam logic [3:0] ADDR_DLL   = 4'h7;
  localparam logic [3:0] ADDR_DLM   = 4'h8;
  localparam logic [3:0] ADDR_EFR   = 4'h9;
  localparam logic [3:0] ADDR_FLOW_RESUME_CHAR_FIRST  = 4'ha;
  localparam logic [3:0] ADDR_FLOW_RESUME_CHAR_SECOND  = 4'hb;
  localparam logic [3:0] ADDR_FLOW_PAUSE_CHAR_FIRST = 4'hc;
  localparam logic [3:0] ADDR_FLOW_PAUSE_CHAR_SECOND = 4'hd;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_ZERO    = 8'h00;
  localparam logic [7:0]  RST_LSR     = 8'h60;
  localparam logic [7:0]  RST_SPR     = 8'hff;
  localparam logic [15:0] RST_DIVISOR = 16'h0001;
  localparam logic [1:0]  RST_ISR_EVT = 2'h0;
  localparam logic        TX_MARK     = 1'b1;

  // ---------------------------------------------------------------
  // Guarded enhanced bits and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] IER_ENH_MASK = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he4;
  localparam int EFR_ENH_BIT      = 4;
  localparam int EFR_SPECIAL_BIT  = 5;
  localparam int IER_FLOWINT_BIT  = 5;
  localparam int ISR_NOINT_BIT    = 0;
  localparam int ISR_EVT_LSB      = 4;

  // Two-bit flow control selection codes, transmit [3:2], receive [1:0]
  localparam logic [1:0] SEL_NONE   = 2'b00;
  localparam logic [1:0] SEL_FIRST  = 2'b10;
  localparam logic [1:0] SEL_SECOND = 2'b01;
  localparam logic [1:0] SEL_BOTH   = 2'b11;

  typedef enum logic [1:0] {
    FC_IDLE   = 2'b00,
    FC_FIRST  = 2'b01,
    FC_SECOND = 2'b10
  } flow_tx_state_t;

endpackage

// *** design/char_match.sv ***
// Equality comparator between a received character and a stored one
`timescale 1ns/10ps
`default_nettype none
module char_match #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] rx_char,
  input  wire logic [WIDTH-1:0] ref_char,
  output logic                  hit
);

  // Bit 0 of the stored character lines up with the first received bit
  assign hit = (rx_char == ref_char); // R11

endmodule
`default_nettype wire

// *** design/uart_flow_ctrl.sv ***
// Software flow control, enhanced bit lock and special character detect
//
// Notes on behaviour
// R01 - Selection field zero after reset: no flow control either way.
// R02 - Transmit bits 3:2: none, first pair, second pair, or both in turn.
// R03 - Receive bits 1:0: none, compare first pair, or second pair.
// R04 - Receive 11, one transmit pair: any resume or any pause matches.
// R05 - Receive 11, transmit 11 or 00: only first-then-second sequences.
// R06 - Guarded enhanced bits change only while the enhance bit is set.
// R07 - Clearing the enhance bit freezes guarded bits against legacy writes.
// R08 - Guarded enhanced bits are zero after reset.
// R09 - Software should normally keep the enhance bit set.
// R10 - Special detect: second pause char is stored and sets status bit 4.
// R11 - Stored character bit 0 matches received character LSB.
// R12 - First-pair receive with special detect: both work independently.
// R13 - Second pair, special on: pause char not stored, interrupts raised.
// R14 - Software keeps the two top enhanced feature bits at zero.
// R15 - Four write-only 8-bit resume and pause character registers.
// R16 - Divisor becomes 0x0001 on power-up only, not on pin reset.
// R17 - Reset: most registers zero, status 0x01, line 0x60, scratch 0xff.
// R18 - In reset serial output idles at mark; interrupt output released.
// R19 - Software clears all selection bits before programming a new setting.
// R20 - Pause suspends transmit after current character; resume restarts it.
`timescale 1ns/10ps
`default_nettype none
module uart_flow_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        por,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  output logic             rx_fifo_push,
  output logic [7:0]       rx_fifo_data,
  output logic             tx_suspend,
  input  wire logic        send_pause_req,
  input  wire logic        send_resume_req,
  output logic             tx_flow_valid,
  output logic [7:0]       tx_flow_char,
  input  wire logic        tx_flow_ready,
  input  wire logic        tx_serial_in,
  output logic             txd,
  output logic             int_out,
  output logic             int_oe,
  input  wire logic [7:0]  line_status_in,
  input  wire logic [7:0]  modem_status_in,
  output logic [7:0]       line_control,
  output logic [7:0]       fifo_control,
  output logic [7:0]       modem_control,
  output logic [15:0]      divisor
);
  import uart_flow_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0]  ier_q, fcr_q, lcr_q, mcr_q, lsr_q, msr_q, spr_q, efr_q;
  logic [7:0]  flow_resume_char_first_q, flow_resume_char_second_q, flow_pause_char_first_q, flow_pause_char_second_q;
  logic [15:0] div_q;
  logic [1:0]  isr_evt_q;
  logic [7:0]  rdata_q;
  logic        prev_on1_q, prev_off1_q, paused_q;
  logic        push_q;
  logic [7:0]  push_data_q;
  logic        txd_q, int_q, int_oe_q;
  flow_tx_state_t st_q, st_d;
  logic        kind_pause_q;
  logic [7:0]  tx_char_q;
  logic        pend_pause_q, pend_resume_q;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire wr_ier   = reg_wr && (reg_addr == ADDR_IER);
  wire wr_fcr   = reg_wr && (reg_addr == ADDR_ISR);
  wire wr_lcr   = reg_wr && (reg_addr == ADDR_LCR);
  wire wr_mcr   = reg_wr && (reg_addr == ADDR_MCR);
  wire wr_spr   = reg_wr && (reg_addr == ADDR_SPR);
  wire wr_dll   = reg_wr && (reg_addr == ADDR_DLL);
  wire wr_dlm   = reg_wr && (reg_addr == ADDR_DLM);
  wire wr_efr   = reg_wr && (reg_addr == ADDR_EFR);
  wire wr_flow_resume_char_first  = reg_wr && (reg_addr == ADDR_FLOW_RESUME_CHAR_FIRST);
  wire wr_flow_resume_char_second  = reg_wr && (reg_addr == ADDR_FLOW_RESUME_CHAR_SECOND);
  wire wr_flow_pause_char_first = reg_wr && (reg_addr == ADDR_FLOW_PAUSE_CHAR_FIRST);
  wire wr_flow_pause_char_second = reg_wr && (reg_addr == ADDR_FLOW_PAUSE_CHAR_SECOND);
  wire rd_isr   = reg_rd && (reg_addr == ADDR_ISR);

  // ---------------------------------------------------------------
  // Enhanced bit lock
  // ---------------------------------------------------------------
  // With the enhance bit clear the guarded bits keep their old value, so
  // legacy drivers that write whole bytes cannot disturb them.
  wire       enh_on  = efr_q[EFR_ENH_BIT];
  wire [7:0] ier_new = enh_on ? reg_wdata : // R06 R07
                       ((reg_wdata & ~IER_ENH_MASK) | (ier_q & IER_ENH_MASK));
  wire [7:0] fcr_new = enh_on ? reg_wdata : // R06 R07
                       ((reg_wdata & ~FCR_ENH_MASK) | (fcr_q & FCR_ENH_MASK));
  wire [7:0] mcr_new = enh_on ? reg_wdata : // R06 R07
                       ((reg_wdata & ~MCR_ENH_MASK) | (mcr_q & MCR_ENH_MASK));

  // ---------------------------------------------------------------
  // Receive comparison
  // ---------------------------------------------------------------
  wire [1:0] rx_sel = efr_q[1:0];
  wire [1:0] tx_sel = efr_q[3:2];
  wire       h_on1, h_on2, h_off1, h_off2;

  // One comparator per stored character, all fed the same received byte
  char_match #(.WIDTH(8)) u_on1 (
    .rx_char  (rx_char),
    .ref_char (flow_resume_char_first_q),
    .hit      (h_on1)
  );
  char_match #(.WIDTH(8)) u_on2 (
    .rx_char  (rx_char),
    .ref_char (flow_resume_char_second_q),
    .hit      (h_on2)
  );
  char_match #(.WIDTH(8)) u_off1 (
    .rx_char  (rx_char),
    .ref_char (flow_pause_char_first_q),
    .hit      (h_off1)
  );
  char_match #(.WIDTH(8)) u_off2 ( // R11
    .rx_char  (rx_char),
    .ref_char (flow_pause_char_second_q),
    .hit      (h_off2)
  );

  wire single_tx = (tx_sel == SEL_FIRST) || (tx_sel == SEL_SECOND);
  wire any_mode  = (rx_sel == SEL_BOTH) && single_tx;  // R04
  wire seq_mode  = (rx_sel == SEL_BOTH) && !single_tx; // R05

  wire pause_hit  = ((rx_sel == SEL_FIRST) && h_off1)            // R03
                 || ((rx_sel == SEL_SECOND) && h_off2)           // R03
                 || (any_mode && (h_off1 || h_off2))             // R04
                 || (seq_mode && prev_off1_q && h_off2);         // R05
  wire resume_hit = ((rx_sel == SEL_FIRST) && h_on1)             // R03
                 || ((rx_sel == SEL_SECOND) && h_on2)            // R03
                 || (any_mode && (h_on1 || h_on2))               // R04
                 || (seq_mode && prev_on1_q && h_on2);           // R05

  // Special detect runs beside flow control; on the second pair the
  // pause character is swallowed instead of stored.
  wire special_hit = efr_q[EFR_SPECIAL_BIT] && h_off2;           // R10 R12
  wire swallow     = pause_hit || resume_hit
                  || (special_hit && (rx_sel == SEL_SECOND));    // R13
  wire push_now    = rx_char_valid && !swallow;                  // R10
  wire pause_evt   = rx_char_valid && (pause_hit || special_hit); // R10 R13
  wire resume_evt  = rx_char_valid && resume_hit;
  wire [1:0] evt_set = {resume_evt, pause_evt};

  // Set wins over the clear caused by reading the status register
  wire [1:0] isr_evt_d = (rd_isr ? RST_ISR_EVT : isr_evt_q) | evt_set;
  wire       irq       = ier_q[IER_FLOWINT_BIT] && (|isr_evt_q);  // R13
  logic [7:0] isr_view;
  always_comb begin
    isr_view                                   = RST_ZERO;
    isr_view[ISR_EVT_LSB +: $bits(isr_evt_q)] = isr_evt_q;
    isr_view[ISR_NOINT_BIT]                    = !irq;
  end

  // ---------------------------------------------------------------
  // Read mux, registered one cycle later
  // ---------------------------------------------------------------
  // Registered read data keep the host timing fixed at one cycle
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_IER: rd_mux = ier_q;
      ADDR_ISR: rd_mux = isr_view;
      ADDR_LCR: rd_mux = lcr_q;
      ADDR_MCR: rd_mux = mcr_q;
      ADDR_LSR: rd_mux = lsr_q;
      ADDR_MSR: rd_mux = msr_q;
      ADDR_SPR: rd_mux = spr_q;
      ADDR_DLL: rd_mux = div_q[7:0];
      ADDR_DLM: rd_mux = div_q[15:8];
      ADDR_EFR: rd_mux = efr_q;
      // Character registers are write-only and read as zero
      default:  rd_mux = RST_ZERO; // R15
    endcase
  end

  // ---------------------------------------------------------------
  // Host registers
  // ---------------------------------------------------------------
  // Reset waits for the enable too, so a frozen block keeps all state
  always_ff @(posedge clk_sys) begin
    if (sys_rst && clk_en) begin
      ier_q   <= RST_ZERO; // R08 R17
      fcr_q   <= RST_ZERO; // R08 R17
      lcr_q   <= RST_ZERO; // R17
      mcr_q   <= RST_ZERO; // R08 R17
      lsr_q   <= RST_LSR;  // R17
      msr_q   <= RST_ZERO; // R17
      spr_q   <= RST_SPR;  // R17
      efr_q   <= RST_ZERO; // R01 R17
      flow_resume_char_first_q  <= RST_ZERO; // R17
      flow_resume_char_second_q  <= RST_ZERO; // R17
      flow_pause_char_first_q <= RST_ZERO; // R17
      flow_pause_char_second_q <= RST_ZERO; // R17
      rdata_q <= RST_ZERO;
    end else if (clk_en) begin
      if (wr_ier)   ier_q   <= ier_new;
      if (wr_fcr)   fcr_q   <= fcr_new;
      if (wr_lcr)   lcr_q   <= reg_wdata;
      if (wr_mcr)   mcr_q   <= mcr_new;
      if (wr_spr)   spr_q   <= reg_wdata;
      if (wr_efr)   efr_q   <= reg_wdata;
      if (wr_flow_resume_char_first)  flow_resume_char_first_q  <= reg_wdata; // R15
      if (wr_flow_resume_char_second)  flow_resume_char_second_q  <= reg_wdata; // R15
      if (wr_flow_pause_char_first) flow_pause_char_first_q <= reg_wdata; // R15
      if (wr_flow_pause_char_second) flow_pause_char_second_q <= reg_wdata; // R15
      lsr_q   <= line_status_in;
      msr_q   <= modem_status_in;
      rdata_q <= reg_rd ? rd_mux : RST_ZERO;
    end
  end

  // Divisor survives the reset pin; only power-up loads it
  always_ff @(posedge clk_sys) begin
    if (por && clk_en) begin
      div_q <= RST_DIVISOR; // R16
    end else if (clk_en) begin
      if (wr_dll) div_q[7:0]  <= reg_wdata;
      if (wr_dlm) div_q[15:8] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Receive path and pause state
  // ---------------------------------------------------------------
  // Pair memory only moves on a real character, so idle cycles between
  // the two halves of a sequence do not break it
  always_ff @(posedge clk_sys) begin
    if (sys_rst && clk_en) begin
      isr_evt_q   <= RST_ISR_EVT; // R08
      prev_on1_q  <= 1'b0;
      prev_off1_q <= 1'b0;
      paused_q    <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= RST_ZERO;
    end else if (clk_en) begin
      isr_evt_q <= isr_evt_d; // R10
      push_q    <= push_now;
      if (rx_char_valid) begin
        prev_on1_q  <= h_on1;
        prev_off1_q <= h_off1;
        push_data_q <= rx_char;
        if (pause_hit) begin
          paused_q <= 1'b1; // R20
        end else if (resume_hit) begin
          paused_q <= 1'b0; // R20
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit flow character sequencer
  // ---------------------------------------------------------------
  // Requests are latched so one arriving while a pair is in flight waits
  wire tx_on   = (tx_sel != SEL_NONE);                        // R02
  wire start   = (st_q == FC_IDLE) && tx_on
              && (pend_pause_q || pend_resume_q);
  wire take_p  = pend_pause_q;
  wire handoff = tx_flow_valid && tx_flow_ready;

  always_comb begin
    case (st_q)
      FC_IDLE:   st_d = start ? FC_FIRST : FC_IDLE;
      FC_FIRST:  st_d = !handoff ? FC_FIRST :
                        ((tx_sel == SEL_BOTH) ? FC_SECOND : FC_IDLE); // R02
      FC_SECOND: st_d = handoff ? FC_IDLE : FC_SECOND;
      default:   st_d = FC_IDLE;
    endcase
  end

  // First character of a kind is pair one unless only pair two is chosen
  wire [7:0] first_char = (tx_sel == SEL_SECOND) ?
                          (take_p ? flow_pause_char_second_q : flow_resume_char_second_q) :
                          (take_p ? flow_pause_char_first_q : flow_resume_char_first_q);        // R02
  wire [7:0] second_char = kind_pause_q ? flow_pause_char_second_q : flow_resume_char_second_q;   // R02

  always_ff @(posedge clk_sys) begin
    if (sys_rst && clk_en) begin
      st_q          <= FC_IDLE;
      kind_pause_q  <= 1'b0;
      tx_char_q     <= RST_ZERO;
      pend_pause_q  <= 1'b0;
      pend_resume_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      // A new request wins over the consumption of an older one
      pend_pause_q  <= (pend_pause_q && !(start && take_p)) || send_pause_req;
      pend_resume_q <= (pend_resume_q && !(start && !take_p))
                    || send_resume_req;
      if (start) begin
        kind_pause_q <= take_p;
        tx_char_q    <= first_char;
      end else if ((st_q == FC_FIRST) && handoff) begin
        tx_char_q <= second_char;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  // Mark during reset keeps the line from showing a false start bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst && clk_en) begin
      txd_q    <= TX_MARK; // R18
      int_q    <= 1'b0;
      int_oe_q <= 1'b0;    // R18
    end else if (clk_en) begin
      txd_q    <= tx_serial_in;
      int_q    <= irq;
      int_oe_q <= 1'b1;
    end
  end

  assign reg_rdata     = rdata_q;
  assign rx_fifo_push  = push_q;
  assign rx_fifo_data  = push_data_q;
  assign tx_suspend    = paused_q; // R20
  assign tx_flow_valid = (st_q == FC_FIRST) || (st_q == FC_SECOND);
  assign tx_flow_char  = tx_char_q;
  assign txd           = txd_q;
  assign int_out       = int_q;
  assign int_oe        = int_oe_q;
  assign line_control  = lcr_q;
  assign fifo_control  = fcr_q;
  assign modem_control = mcr_q;
  assign divisor       = div_q;

endmodule
`default_nettype wire

// *** testbench/uart_flow_ctrl_monitor.sv ***
// Port-level checks for the flow control block
`timescale 1ns/10ps
`default_nettype none
module uart_flow_ctrl_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        por,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        rx_char_valid,
  input wire logic [7:0]  rx_char,
  input wire logic        rx_fifo_push,
  input wire logic [7:0]  rx_fifo_data,
  input wire logic        tx_suspend,
  input wire logic        tx_flow_valid,
  input wire logic [7:0]  tx_flow_char,
  input wire logic        tx_flow_ready,
  input wire logic        txd,
  input wire logic        int_oe,
  input wire logic [7:0]  line_control,
  input wire logic [7:0]  fifo_control,
  input wire logic [7:0]  modem_control,
  input wire logic [15:0] divisor
);
  // ---------------------------------------------------------------
  // Shadow of the selection field
  // ---------------------------------------------------------------
  logic [7:0] feat_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      feat_q <= 8'h00;
    else if (clk_en && reg_wr && reg_addr == 4'h9)
      feat_q <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_wo_read;
    reg_rd && reg_addr >= 4'ha && reg_addr <= 4'hd |=> reg_rdata == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("char readable");
  // Reset checks cannot be disabled by the reset they watch
  property p_rst_pins;
    disable iff (!clk_en) sys_rst |=> txd && !int_oe;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("reset pins");
  property p_rst_ctrl;
    disable iff (!clk_en) sys_rst |=> line_control == 8'h00
      && fifo_control == 8'h00 && modem_control == 8'h00 && !tx_flow_valid;
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl) else $error("reset ctrl");
  property p_por_div;
    disable iff (!clk_en) por |=> divisor == 16'h0001;
  endproperty
  a_por_div: assert property (p_por_div) else $error("divisor not 1");
  property p_div_keep;
    disable iff (!clk_en) sys_rst && !por |=> $stable(divisor);
  endproperty
  a_div_keep: assert property (p_div_keep) else $error("divisor reset");
  property p_tx_off;
    feat_q[3:2] == 2'b00 |-> !tx_flow_valid;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("flow char sent");
  property p_flow_hold;
    tx_flow_valid && !tx_flow_ready |=> tx_flow_valid && $stable(tx_flow_char);
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("offer lost");
  property p_push;
    rx_fifo_push |-> $past(rx_char_valid) && rx_fifo_data == $past(rx_char);
  endproperty
  a_push: assert property (p_push) else $error("push data wrong");
  property p_susp;
    $rose(tx_suspend) |-> $past(rx_char_valid);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend uncaused");

  c_push: cover property (rx_fifo_push);
  c_susp: cover property ($rose(tx_suspend));
  c_hand: cover property (tx_flow_valid && tx_flow_ready);
endmodule

bind uart_flow_ctrl uart_flow_ctrl_monitor mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .por(por), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
  .rx_char(rx_char), .rx_fifo_push(rx_fifo_push),
  .rx_fifo_data(rx_fifo_data), .tx_suspend(tx_suspend),
  .tx_flow_valid(tx_flow_valid), .tx_flow_char(tx_flow_char),
  .tx_flow_ready(tx_flow_ready), .txd(txd), .int_oe(int_oe),
  .line_control(line_control), .fifo_control(fifo_control),
  .modem_control(modem_control), .divisor(divisor));
`default_nettype wire

// *** testbench/flow_station.sv ***
// Transmitter side taking flow characters, with a slow handshake
`timescale 1ns/10ps
`default_nettype none
module flow_station (
  input  wire logic       clk_sys,
  input  wire logic       tx_flow_valid,
  input  wire logic [7:0] tx_flow_char,
  output var logic        tx_flow_ready
);
  logic [7:0] log [0:15];
  int         cnt = 0;
  initial tx_flow_ready = 1'b0;
  // Ready every other cycle, so each offer must stand at least once
  always @(posedge clk_sys) begin
    if (tx_flow_valid && tx_flow_ready) begin
      log[cnt] <= tx_flow_char;
      cnt <= cnt + 1;
    end
    tx_flow_ready <= tx_flow_valid && !tx_flow_ready;
  end
endmodule
`default_nettype wire

// *** testbench/uart_flow_ctrl_test.sv ***
// Self-checking bench for the flow control block
`timescale 1ns/10ps
`default_nettype none
module uart_flow_ctrl_test;
  logic            clk_sys, sys_rst, por, reg_wr, reg_rd, rx_char_valid;
  logic            send_pause_req, send_resume_req;
  logic [3:0]      reg_addr;
  logic [7:0]      reg_wdata, rx_char, got;
  wire logic [7:0] reg_rdata, rx_fifo_data, tx_flow_char;
  wire logic [7:0] line_control, fifo_control, modem_control;
  wire logic       rx_fifo_push, tx_suspend, tx_flow_valid, tx_flow_ready;
  wire logic       txd, int_out, int_oe;
  wire logic [15:0] divisor;
  int              n_fail = 0, comparisons = 0, cyc = 0;

  uart_flow_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .por(por),
    .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_fifo_push(rx_fifo_push), .rx_fifo_data(rx_fifo_data),
    .tx_suspend(tx_suspend), .send_pause_req(send_pause_req),
    .send_resume_req(send_resume_req), .tx_flow_valid(tx_flow_valid),
    .tx_flow_char(tx_flow_char), .tx_flow_ready(tx_flow_ready),
    .tx_serial_in(1'b0), .txd(txd), .int_out(int_out), .int_oe(int_oe),
    .line_status_in(8'h60), .modem_status_in(8'h00),
    .line_control(line_control), .fifo_control(fifo_control),
    .modem_control(modem_control), .divisor(divisor));
  flow_station st (.clk_sys(clk_sys), .tx_flow_valid(tx_flow_valid),
    .tx_flow_char(tx_flow_char), .tx_flow_ready(tx_flow_ready));

  // ---------------------------------------------------------------
  // Clock, hang guard, shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdq(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rdq(a);
    chk(got, e);
  endtask
  task automatic rx(input logic [7:0] c, input logic push, input logic sp);
    @(posedge clk_sys);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    #1 chk(rx_fifo_push, push);
    chk(tx_suspend, sp);
    if (push) chk(rx_fifo_data, c);
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals();
    logic [3:0] a [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                           4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
    logic [7:0] e [13] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'hff,
                           8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    chk(divisor, 16'h0001);
    for (int i = 0; i < 13; i++) rd(a[i], e[i]);
    chk(int_oe, 1'b1);
  endtask
  task automatic t_guard();
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h0f);
    wr(4'h9, 8'h10);
    wr(4'h0, 8'hff);
    wr(4'h3, 8'hff);
    wr(4'h1, 8'h30);
    rd(4'h0, 8'hff);
    chk(modem_control, 8'hff);
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h00);
    rd(4'h0, 8'hf0);
    chk(modem_control, 8'he4);
    chk(fifo_control, 8'h30);
    wr(4'h7, 8'h34);
    wr(4'h8, 8'h12);
    @(posedge clk_sys) sys_rst <= 1'b1;
    @(posedge clk_sys) sys_rst <= 1'b0;
    #1 chk({txd, int_oe}, 2'b10);
    chk(divisor, 16'h1234);
    rd(4'h0, 8'h00);
    chk(modem_control, 8'h00);
    chk(fifo_control, 8'h00);
  endtask
  task automatic t_tx();
    logic [7:0] s [3] = '{8'h08, 8'h04, 8'h0c};
    logic [7:0] e [8] = '{8'h33, 8'h11, 8'h44, 8'h22,
                          8'h33, 8'h44, 8'h11, 8'h22};
    int         n [3] = '{2, 4, 8};
    int         k = 0;
    for (int i = 0; i < 4; i++) wr(4'ha + 4'(i), 8'h11 * 8'(i + 1));
    @(posedge clk_sys) {send_pause_req, send_resume_req} <= 2'b11;
    @(posedge clk_sys) {send_pause_req, send_resume_req} <= 2'b00;
    repeat (8) @(posedge clk_sys);
    chk(16'(st.cnt), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(4'h9, 8'h00);
      wr(4'h9, s[i]);
      if (i > 0) begin
        @(posedge clk_sys) {send_pause_req, send_resume_req} <= 2'b11;
        @(posedge clk_sys) {send_pause_req, send_resume_req} <= 2'b00;
      end
      for (int j = 0; j < 60 && st.cnt < n[i]; j++) @(posedge clk_sys);
      chk(16'(st.cnt), 16'(n[i]));
      for (; k < n[i]; k++) chk(st.log[k], e[k]);
    end
    wr(4'h9, 8'h00);
  endtask
  task automatic t_rx();
    wr(4'h9, 8'h02);
    rx(8'h33, 1'b0, 1'b1);
    rx(8'h55, 1'b1, 1'b1);
    rx(8'h11, 1'b0, 1'b0);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h01);
    rx(8'h44, 1'b0, 1'b1);
    rx(8'h33, 1'b1, 1'b1);
    rx(8'h22, 1'b0, 1'b0);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h0b);
    rx(8'h44, 1'b0, 1'b1);
    rx(8'h11, 1'b0, 1'b0);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h03);
    rx(8'h44, 1'b1, 1'b0);
    rx(8'h33, 1'b1, 1'b0);
    rx(8'h44, 1'b0, 1'b1);
    rx(8'h11, 1'b1, 1'b1);
    rx(8'h22, 1'b0, 1'b0);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h22);
    rdq(4'h1);
    rx(8'h44, 1'b1, 1'b0);
    rdq(4'h1);
    chk(got[4], 1'b1);
    rx(8'h33, 1'b0, 1'b1);
    rx(8'h11, 1'b0, 1'b0);
    wr(4'h9, 8'h10);
    wr(4'h0, 8'h20);
    wr(4'h9, 8'h31);
    rdq(4'h1);
    rx(8'h44, 1'b0, 1'b1);
    @(posedge clk_sys);
    #1 chk(int_out, 1'b1);
    rdq(4'h1);
    chk(got[4], 1'b1);
    rx(8'h22, 1'b0, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {sys_rst, por} = 2'b11;
    {reg_wr, reg_rd, rx_char_valid} = 3'b000;
    {send_pause_req, send_resume_req} = 2'b00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    rx_char = 8'h00;
    repeat (5) @(posedge clk_sys);
    {sys_rst, por} <= 2'b00;
    t_reset_vals();
    t_guard();
    t_tx();
    t_rx();
    complete_run();
  end
endmodule
`default_nettype wire
